// File: src/spiirc_pkg.sv
// shared constants for the serial interface interrupt and reset control block
package spiirc_pkg;
	localparam int BITS_PER_BYTE = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] FIRST_OUT_INDEX = 3'h7;
	localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
	// half a serial bit, in bus clock cycles, per rate select code
	localparam logic [6:0] HALF_DIV2 = 7'h01;
	localparam logic [6:0] HALF_DIV8 = 7'h04;
	localparam logic [6:0] HALF_DIV32 = 7'h10;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
	localparam logic [1:0] RATE_DIV2 = 2'h0;
	localparam logic [1:0] RATE_DIV8 = 2'h1;
	localparam logic [1:0] RATE_DIV32 = 2'h2;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic TX_EMPTY_RESET = 1'b1;
	localparam logic ENABLE_RESET = 1'b0;
	typedef enum logic [1:0] {MST_IDLE, MST_LOW, MST_HIGH} spiirc_mst_e;
endpackage

// File: src/spiirc_slave_link.sv
// slave side shifter clocked by the incoming serial clock
`timescale 1ns/1ns
module spiirc_slave_link
	import spiirc_pkg::*;
(
	input wire logic link_clock_i,
	input wire logic frame_rst_i,
	input wire logic rst_i,
	input wire logic mosi_i,
	input wire logic [7:0] tx_word_i,
	output logic miso_o,
	output logic [7:0] rx_byte_o,
	output logic done_toggle_o
);
	logic [2:0] count;
	logic [7:0] shift;
	logic [2:0] out_index;
	// frame reset drops with slave select, so no edge is needed to end a frame
	always_ff @(posedge link_clock_i or posedge frame_rst_i)
	begin
		if (frame_rst_i)
		begin
			count <= 3'h0;
			shift <= BYTE_RESET;
		end
		else
		begin
			shift <= {shift[6:0], mosi_i};
			count <= count + 3'h1;
		end
	end
	// toggle survives frame resets so the bus side never sees a false event
	always_ff @(posedge link_clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rx_byte_o <= BYTE_RESET;
			done_toggle_o <= 1'b0;
		end
		else if (count == LAST_BIT)
		begin
			rx_byte_o <= {shift[6:0], mosi_i};
			done_toggle_o <= ~done_toggle_o;
		end
	end
	// output moves on the falling edge, msb presented as soon as selected
	always_ff @(negedge link_clock_i or posedge frame_rst_i)
	begin
		if (frame_rst_i)
			out_index <= FIRST_OUT_INDEX;
		else
			out_index <= out_index - 3'h1;
	end
	assign miso_o = tx_word_i[out_index];
endmodule

// File: src/spiirc_sync.sv
// two flip-flop level synchroniser into the bus clock domain
`timescale 1ns/1ns
module spiirc_sync
	import spiirc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic rst_value_i,
	input wire logic d_i,
	output logic q_o
);
	logic stage1;
	logic stage2;
	// reset value is a constant per instance; rst_value_i is tied at the instance
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end
		else
		begin
			stage1 <= d_i ^ rst_value_i;
			stage2 <= stage1;
		end
	end
	assign q_o = stage2 ^ rst_value_i;
endmodule

// File: src/spiirc_top.sv
// serial interface interrupt, queuing, reset and pin control logic
// What this block does
// - transmit interrupt when transmit-empty set and its enable set.
// - receive interrupt from receive-full only with its enable and module enabled.
// - error enable gates overflow and mode fault together onto receive/error interrupt.
// - mode fault never set while fault detection is disabled.
// - receive-full set whenever a completed byte reaches the receive register.
// - transmit-empty set whenever a byte moves into the shift register.
// - double-buffered transmit; master starts a queued byte right after the previous one.
// - slave with no new byte resends its previous word.
// - system reset returns everything to its reset state.
// - disabled module sets transmit-empty, aborts, clears shifter and counter, frees pins.
// - disabling keeps control bits and receive, overflow, fault flags.
// - module disabled by software clear or by a master mode fault.
// - in wait, module runs, register access blocked, enabled interrupt wakes cpu.
// - in stop, master transfer halts with state kept and resumes afterwards.
// - in break without clear enable, flags hold; two-step clear finishes after break.
// - with break clear enable, flags clear during break and stay cleared.
// - data write in protected break does nothing.
// - miso driven only as selected slave; otherwise released.
// - enabled module owns direction of miso, mosi and serial clock pins.
// - clock out as master, in as slave; eight clocks per byte.
// - wired-or mode makes mosi open drain.
// - master fault: interrupt, disable, set transmit-empty, clear counter, free pins.
// - overflow set and byte discarded if receive register still full at bit 1 as master, at byte end as slave.
// - any data read outside wait and protected break clears receive-full.
`timescale 1ns/1ns
module spiirc_top
	import spiirc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic serial_clock_pin_i,
	input wire logic module_enable_set_i,
	input wire logic module_enable_clr_i,
	input wire logic master_select_i,
	input wire logic wired_or_mode_i,
	input wire logic tx_irq_enable_i,
	input wire logic rx_irq_enable_i,
	input wire logic error_irq_enable_i,
	input wire logic fault_detect_enable_i,
	input wire logic rate_select_hi_i,
	input wire logic rate_select_lo_i,
	input wire logic data_write_i,
	input wire logic [7:0] data_wdata_i,
	input wire logic data_read_i,
	input wire logic status_read_i,
	input wire logic control_write_i,
	input wire logic wait_i,
	input wire logic stop_i,
	input wire logic break_i,
	input wire logic break_clear_enable_i,
	input wire logic miso_i,
	input wire logic mosi_i,
	input wire logic ss_n_i,
	output logic miso_o,
	output logic miso_oe_o,
	output logic mosi_o,
	output logic mosi_oe_o,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe_o,
	output logic port_control_o,
	output logic module_enable_o,
	output logic tx_empty_flag_o,
	output logic rx_full_flag_o,
	output logic overflow_flag_o,
	output logic mode_fault_flag_o,
	output logic [7:0] data_reg_o,
	output logic tx_irq_o,
	output logic rx_irq_o,
	output logic wake_o
);
	logic module_enable, tx_empty_flag, rx_full_flag, overflow_flag, mode_fault_flag, overflow_armed, fault_armed;
	logic [7:0] tx_buf, data_reg, shreg, slave_tx_word, link_rx_byte, done_byte;
	logic [6:0] half_cnt, half_len;
	logic [3:0] bit_cnt;
	logic sck, mosi_bit, discard, slave_active, ss_sync, ss_prev, miso_sync, done_sync, done_prev, link_miso;
	logic link_done_toggle, frame_rst, access_ok, clear_ok, write_ok, half_end, load_master, load_slave;
	logic master_capture, master_done, slave_done, master_fault, slave_fault, fault_cond, slave_mode, master_mode;
	spiirc_mst_e state;

	spiirc_sync u_ss_sync (.clock_i(clock_i), .rst_i(rst_i), .rst_value_i(1'b1),
		.d_i(ss_n_i), .q_o(ss_sync));
	spiirc_sync u_miso_sync (.clock_i(clock_i), .rst_i(rst_i), .rst_value_i(1'b0),
		.d_i(miso_i), .q_o(miso_sync));
	spiirc_sync u_done_sync (.clock_i(clock_i), .rst_i(rst_i), .rst_value_i(1'b0),
		.d_i(link_done_toggle), .q_o(done_sync));
	// slave word is only changed while deselected, so the link reads it as static
	spiirc_slave_link u_link (
		.link_clock_i(serial_clock_pin_i), .frame_rst_i(frame_rst), .rst_i(rst_i), .mosi_i(mosi_i),
		.tx_word_i(slave_tx_word), .miso_o(link_miso), .rx_byte_o(link_rx_byte), .done_toggle_o(link_done_toggle)
	);
	assign frame_rst = rst_i | ss_n_i | ~slave_mode;

	assign slave_mode = module_enable & ~master_select_i;
	assign master_mode = module_enable & master_select_i;
	assign access_ok = ~wait_i;
	assign clear_ok = ~break_i | break_clear_enable_i;
	assign write_ok = data_write_i & access_ok & clear_ok;

	always_comb
	begin
		case ({rate_select_hi_i, rate_select_lo_i})
			RATE_DIV2: half_len = HALF_DIV2;
			RATE_DIV8: half_len = HALF_DIV8;
			RATE_DIV32: half_len = HALF_DIV32;
			default: half_len = HALF_DIV128;
		endcase
	end

	assign half_end = (half_cnt == half_len - 7'h01) & ~stop_i;
	assign load_master = master_mode & (state == MST_IDLE) & ~tx_empty_flag & ~stop_i;
	assign load_slave = slave_mode & ~tx_empty_flag & ~slave_active & ss_sync;
	assign master_capture = master_mode & (state == MST_HIGH) & half_end;
	assign master_done = master_capture & (bit_cnt == {1'b0, LAST_BIT});
	assign slave_done = slave_mode & (done_sync ^ done_prev);
	assign done_byte = master_done ? {shreg[6:0], miso_sync} : link_rx_byte;
	assign master_fault = master_mode & fault_detect_enable_i & ~ss_sync;
	assign slave_fault = slave_mode & fault_detect_enable_i & slave_active & ss_sync & ~ss_prev;
	assign fault_cond = master_fault | slave_fault;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ss_prev <= 1'b1;
			done_prev <= 1'b0;
		end
		else
		begin
			ss_prev <= ss_sync;
			done_prev <= done_sync;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			module_enable <= ENABLE_RESET;
		else if (master_fault | (module_enable_clr_i & access_ok))
			module_enable <= 1'b0;
		else if (module_enable_set_i & access_ok)
			module_enable <= 1'b1;
	end

	// master engine: low half drives data, falling edge captures and shifts
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= MST_IDLE;
			shreg <= BYTE_RESET;
			bit_cnt <= BIT_COUNT_RESET;
			half_cnt <= 7'h00;
			sck <= 1'b0;
			mosi_bit <= 1'b0;
		end
		else if (~master_mode)
		begin
			state <= MST_IDLE;
			shreg <= BYTE_RESET;
			bit_cnt <= BIT_COUNT_RESET;
			half_cnt <= 7'h00;
			sck <= 1'b0;
			mosi_bit <= 1'b0;
		end
		else
		begin
			case (state)
				MST_IDLE:
				begin
					if (load_master)
					begin
						shreg <= tx_buf;
						mosi_bit <= tx_buf[7];
						bit_cnt <= BIT_COUNT_RESET;
						half_cnt <= 7'h00;
						state <= MST_LOW;
					end
				end
				MST_LOW:
				begin
					if (half_end)
					begin
						sck <= 1'b1;
						half_cnt <= 7'h00;
						state <= MST_HIGH;
					end
					else if (~stop_i)
						half_cnt <= half_cnt + 7'h01;
				end
				MST_HIGH:
				begin
					if (half_end)
					begin
						sck <= 1'b0;
						half_cnt <= 7'h00;
						shreg <= {shreg[6:0], miso_sync};
						mosi_bit <= shreg[6];
						bit_cnt <= bit_cnt + 4'h1;
						state <= master_done ? MST_IDLE : MST_LOW;
					end
					else if (~stop_i)
						half_cnt <= half_cnt + 7'h01;
				end
				default: state <= MST_IDLE;
			endcase
		end
	end

	// slave selection window; a fault is a deselect before the byte completes
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			slave_active <= 1'b0;
		else if (~slave_mode | slave_done | ss_sync)
			slave_active <= 1'b0;
		else if (~ss_sync & ss_prev)
			slave_active <= 1'b1;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			slave_tx_word <= BYTE_RESET;
		else if (load_slave)
			slave_tx_word <= tx_buf;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			tx_buf <= BYTE_RESET;
		else if (write_ok & module_enable)
			tx_buf <= data_wdata_i;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			tx_empty_flag <= TX_EMPTY_RESET;
		else if (~module_enable | master_fault | load_master | load_slave)
			tx_empty_flag <= 1'b1;
		else if (write_ok)
			tx_empty_flag <= 1'b0;
	end

	// overflow is decided at the first capture so the unread byte is kept
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			discard <= 1'b0;
		else if (load_master)
			discard <= 1'b0;
		else if (master_capture & (bit_cnt == BIT_COUNT_RESET))
			discard <= rx_full_flag;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			data_reg <= BYTE_RESET;
		else if ((master_done & ~discard) | (slave_done & ~rx_full_flag))
			data_reg <= done_byte;
	end

	// flag sets win over clears landing in the same cycle
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			rx_full_flag <= FLAG_RESET;
		else if ((master_done & ~discard) | (slave_done & ~rx_full_flag))
			rx_full_flag <= 1'b1;
		else if (data_read_i & access_ok & clear_ok)
			rx_full_flag <= 1'b0;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			overflow_armed <= 1'b0;
		else if (~overflow_flag)
			overflow_armed <= 1'b0;
		else if (status_read_i & access_ok)
			overflow_armed <= 1'b1;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			overflow_flag <= FLAG_RESET;
		else if ((master_capture & (bit_cnt == BIT_COUNT_RESET) & rx_full_flag) | (slave_done & rx_full_flag))
			overflow_flag <= 1'b1;
		else if (overflow_armed & data_read_i & access_ok & clear_ok)
			overflow_flag <= 1'b0;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			fault_armed <= 1'b0;
		else if (~mode_fault_flag)
			fault_armed <= 1'b0;
		else if (status_read_i & access_ok)
			fault_armed <= 1'b1;
	end

	// clearing needs the fault condition gone, otherwise the flag stays
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			mode_fault_flag <= FLAG_RESET;
		else if (fault_cond)
			mode_fault_flag <= 1'b1;
		else if (fault_armed & control_write_i & access_ok & clear_ok)
			mode_fault_flag <= 1'b0;
	end

	// pins go back to the port whenever the module is off
	assign port_control_o = ~module_enable;
	assign miso_oe_o = slave_mode & ~ss_n_i;
	assign miso_o = link_miso & miso_oe_o;
	assign serial_clock_pin_oe_o = master_mode;
	assign serial_clock_pin_o = sck;
	// open drain drives only the low level
	assign mosi_oe_o = master_mode & (~wired_or_mode_i | ~mosi_bit);
	assign mosi_o = mosi_bit & ~wired_or_mode_i;

	assign module_enable_o = module_enable;
	assign tx_empty_flag_o = tx_empty_flag;
	assign rx_full_flag_o = rx_full_flag;
	assign overflow_flag_o = overflow_flag;
	assign mode_fault_flag_o = mode_fault_flag;
	assign data_reg_o = data_reg;
	assign tx_irq_o = tx_empty_flag & tx_irq_enable_i;
	assign rx_irq_o = (rx_full_flag & rx_irq_enable_i & module_enable)
		| (error_irq_enable_i & (overflow_flag | mode_fault_flag));
	assign wake_o = wait_i & (tx_irq_o | rx_irq_o);

	a_tx_irq_gate: assert property (@(posedge clock_i) disable iff (rst_i)
		tx_irq_o |-> tx_empty_flag_o && tx_irq_enable_i) else $error("tx irq without cause");
	a_rx_irq_enable: assert property (@(posedge clock_i) disable iff (rst_i)
		(!module_enable_o && !error_irq_enable_i) |-> !rx_irq_o) else $error("rx irq while disabled");
	a_error_gate: assert property (@(posedge clock_i) disable iff (rst_i)
		(error_irq_enable_i && (overflow_flag_o || mode_fault_flag_o)) |-> rx_irq_o)
		else $error("error flag not signalled");
	a_fault_needs_enable: assert property (@(posedge clock_i) disable iff (rst_i)
		$rose(mode_fault_flag_o) |-> $past(fault_detect_enable_i)) else $error("fault set while detection off");
	a_byte_sets_full: assert property (@(posedge clock_i) disable iff (rst_i)
		(master_done && !discard) |=> rx_full_flag_o && data_reg_o == $past(done_byte))
		else $error("received byte not stored");
	a_load_sets_empty: assert property (@(posedge clock_i) disable iff (rst_i)
		load_master |=> tx_empty_flag_o && state == MST_LOW) else $error("load did not empty buffer");
	a_disable_resets: assert property (@(posedge clock_i) disable iff (rst_i)
		!module_enable_o |-> !serial_clock_pin_oe_o ##1 (tx_empty_flag_o && bit_cnt == 4'h0))
		else $error("partial reset incomplete");
	a_master_fault: assert property (@(posedge clock_i) disable iff (rst_i)
		master_fault |=> !module_enable_o && tx_empty_flag_o && mode_fault_flag_o && port_control_o)
		else $error("master fault actions missing");
	a_break_frozen: assert property (@(posedge clock_i) disable iff (rst_i)
		(break_i && !break_clear_enable_i && rx_full_flag_o) |=> rx_full_flag_o)
		else $error("flag cleared during break");
	a_break_write: assert property (@(posedge clock_i) disable iff (rst_i)
		(break_i && !break_clear_enable_i && tx_empty_flag_o) |=> tx_empty_flag_o)
		else $error("break write had effect");
	a_miso_release: assert property (@(posedge clock_i) disable iff (rst_i)
		miso_oe_o |-> !master_select_i && module_enable_o && !ss_n_i) else $error("miso driven unselected");
	a_eight_bits: assert property (@(posedge clock_i) disable iff (rst_i)
		master_done |-> bit_cnt == 4'h7 && state == MST_HIGH) else $error("byte not eight bits");
endmodule

// File: verification/spiirc_far_end.sv
// far end of the serial link: slave to a design master, master to a design slave
`timescale 1ns/1ns
module spiirc_far_end (
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	output logic sck_o,
	output logic ss_n_o,
	output logic mosi_o,
	output logic miso_o,
	output logic [7:0] got_o
);
	logic [7:0] tx_word = 8'h00;
	assign miso_o = tx_word[7];
	initial
	begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b1;
	end
	// sample on rising clock, msb first
	always @(posedge sck_i)
		got_o <= {got_o[6:0], mosi_i};
	// inverted fill, so a stale bit never passes for data
	always @(negedge sck_i)
		tx_word <= {tx_word[6:0], ~tx_word[7]};
	task automatic load(input logic [7:0] w);
		tx_word = w;
	endtask
	// one framed byte of eight clocks; clock stands still outside the frame
	task automatic xfer(input logic [7:0] out, output logic [7:0] seen);
		seen = 8'h00;
		ss_n_o = 1'b0;
		#60;
		for (int i = 7; i >= 0; i--)
		begin
			mosi_o = out[i];
			#7 sck_o = 1'b1;
			seen = {seen[6:0], miso_i};
			#8 sck_o = 1'b0;
		end
		#60 mosi_o = ~mosi_o;
		ss_n_o = 1'b1;
		#100;
	endtask
endmodule

// File: verification/test_spiirc_top.sv
// self-checking bench for the serial interrupt, queuing and reset control block
`timescale 1ns/1ns
module test_spiirc_top
	import spiirc_pkg::*;
;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic en_set = 1'b0, en_clr = 1'b0, mst = 1'b1, wom = 1'b0, tie = 1'b0, rie = 1'b0, eie = 1'b0;
	logic fde = 1'b0, wr = 1'b0, rd = 1'b0, srd = 1'b0, cwr = 1'b0, wt = 1'b0, stp = 1'b0;
	logic brk = 1'b0, bce = 1'b0, flt = 1'b0, s;
	logic [1:0] rate = 2'h1;
	logic [7:0] wdata = 8'h00, tx, far, seen, dreg, far_got;
	logic miso_w, mosi_w, sck_w, ss_w, far_sck, far_ss_n, far_mosi, far_miso;
	logic d_miso, d_miso_oe, d_mosi, d_mosi_oe, d_sck, d_sck_oe, port_ctl, en, te, rf, ov, mf, tirq, rirq, wake;
	int errors = 0, cmp_count = 0, cycles = 0;
	// rate, wired-or, tx irq enable, rx irq enable, byte sent, byte from far end
	logic [20:0] rows [4] = '{{2'h1, 1'b0, 1'b1, 1'b1, 8'ha5, 8'h3c}, {2'h2, 1'b1, 1'b0, 1'b1, 8'h0f, 8'hf0},
		{2'h3, 1'b0, 1'b1, 1'b0, 8'h81, 8'h7e}, {2'h1, 1'b1, 1'b0, 1'b0, 8'h00, 8'hff}};
	assign miso_w = d_miso_oe ? d_miso : far_miso;
	// pull-up on the data line while nobody drives it
	assign mosi_w = d_mosi_oe ? d_mosi : (mst ? 1'b1 : far_mosi);
	assign sck_w = d_sck_oe ? d_sck : far_sck;
	assign ss_w = far_ss_n & ~flt;
	spiirc_top i_spiirc_top (
		.clock_i(clock_i), .rst_i(rst_i), .serial_clock_pin_i(sck_w), .module_enable_set_i(en_set),
		.module_enable_clr_i(en_clr), .master_select_i(mst), .wired_or_mode_i(wom), .tx_irq_enable_i(tie),
		.rx_irq_enable_i(rie), .error_irq_enable_i(eie), .fault_detect_enable_i(fde), .rate_select_hi_i(rate[1]),
		.rate_select_lo_i(rate[0]), .data_write_i(wr), .data_wdata_i(wdata), .data_read_i(rd),
		.status_read_i(srd), .control_write_i(cwr), .wait_i(wt), .stop_i(stp), .break_i(brk),
		.break_clear_enable_i(bce), .miso_i(miso_w), .mosi_i(mosi_w), .ss_n_i(ss_w), .miso_o(d_miso),
		.miso_oe_o(d_miso_oe), .mosi_o(d_mosi), .mosi_oe_o(d_mosi_oe), .serial_clock_pin_o(d_sck),
		.serial_clock_pin_oe_o(d_sck_oe), .port_control_o(port_ctl), .module_enable_o(en), .tx_empty_flag_o(te),
		.rx_full_flag_o(rf), .overflow_flag_o(ov), .mode_fault_flag_o(mf), .data_reg_o(dreg), .tx_irq_o(tirq),
		.rx_irq_o(rirq), .wake_o(wake)
	);
	spiirc_far_end i_spiirc_far_end (
		.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(far_sck), .ss_n_o(far_ss_n),
		.mosi_o(far_mosi), .miso_o(far_miso), .got_o(far_got)
	);
	always #10 clock_i = ~clock_i;
	task automatic stop_test();
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// whole run needs about a tenth of this
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			stop_test();
		end
	end
	task automatic tick();
		@(posedge clock_i);
		#2;
	endtask
	task automatic chk(input string n, input logic [7:0] v, input logic [7:0] e);
		cmp_count++;
		if (v !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic chkb(input string n, input logic v, input logic e);
		chk(n, {7'h00, v}, {7'h00, e});
	endtask
	task automatic cpu(input logic w, input logic r, input logic sr, input logic cw, input logic [7:0] d);
		{wr, rd, srd, cwr, wdata} = {w, r, sr, cw, d};
		tick();
		{wr, rd, srd, cwr} = 4'h0;
		tick();
	endtask
	task automatic pulse_en(input logic on);
		{en_set, en_clr} = {on, ~on};
		tick();
		{en_set, en_clr} = 2'h0;
		tick();
	endtask
	// 0 receive-full, 1 overflow
	task automatic wait_hi(input int sel);
		for (int i = 0; i < 3000 && {ov, rf} >> sel !== 2'h1 && ({ov, rf} >> sel) % 2 !== 1; i++)
			tick();
	endtask
	task automatic chk_reset();
		chkb("enable", en, ENABLE_RESET);
		chkb("tx_empty", te, TX_EMPTY_RESET);
		chkb("rx_full", rf, FLAG_RESET);
		chkb("overflow", ov, FLAG_RESET);
		chkb("fault", mf, FLAG_RESET);
		chkb("port", port_ctl, 1'b1);
		chk("data", dreg, BYTE_RESET);
	endtask
	// wired-or: driven only to pull low
	always @(negedge clock_i)
		if (wom && d_mosi_oe)
			chkb("mosi_od", d_mosi, 1'b0);
	initial
	begin
		repeat (3) @(posedge clock_i);
		#2 rst_i = 1'b0;
		chk_reset();
		repeat (3) tick();
		pulse_en(1'b1);
		for (int k = 0; k < 4; k++)
		begin
			{rate, wom, tie, rie, tx, far} = rows[k];
			i_spiirc_far_end.load(far);
			cpu(1'b1, 1'b0, 1'b0, 1'b0, tx); // written while empty
			tick();
			chkb("tx_empty", te, 1'b1);
			chkb("tx_irq", tirq, tie);
			chkb("sck_oe", d_sck_oe, 1'b1);
			wait_hi(0);
			chk("rx_byte", dreg, far);
			chk("far_byte", far_got, tx);
			chkb("rx_irq", rirq, rie);
			cpu(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
			chkb("rx_read", rf, 1'b0);
		end
		{rate, wom, tie, rie, eie} = 6'h11;
		i_spiirc_far_end.load(8'hc3);
		cpu(1'b1, 1'b0, 1'b0, 1'b0, 8'h5a);
		tick();
		cpu(1'b1, 1'b0, 1'b0, 1'b0, 8'h96); // queued while empty
		chkb("queued", te, 1'b0);
		wait_hi(0);
		repeat (3) tick();
		chkb("requeued", te, 1'b1);
		chk("first_rx", dreg, 8'hc3);
		wait_hi(1);
		chkb("err_irq", rirq, 1'b1);
		eie = 1'b0;
		tick();
		chkb("err_mask", rirq, 1'b0);
		eie = 1'b1;
		repeat (80) tick();
		chk("kept_rx", dreg, 8'hc3);
		chk("second_tx", far_got, 8'h96);
		cpu(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
		brk = 1'b1;
		cpu(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		chkb("ovf_held", ov, 1'b1);
		chkb("rxf_held", rf, 1'b1);
		cpu(1'b1, 1'b0, 1'b0, 1'b0, 8'h11);
		chkb("brk_write", te, 1'b1);
		bce = 1'b1;
		cpu(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		{brk, bce} = 2'h0;
		tick();
		chkb("ovf_clr", ov, 1'b0);
		chkb("rxf_clr", rf, 1'b0);
		flt = 1'b1;
		repeat (6) tick();
		chkb("no_fault", mf, 1'b0);
		fde = 1'b1;
		repeat (5) tick();
		chkb("fault", mf, 1'b1);
		chkb("fault_off", en, 1'b0);
		chkb("fault_te", te, 1'b1);
		chkb("fault_port", port_ctl, 1'b1);
		chkb("fault_irq", rirq, 1'b1);
		flt = 1'b0;
		repeat (4) tick();
		cpu(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
		chkb("fault_kept", mf, 1'b1);
		cpu(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
		chkb("fault_clr", mf, 1'b0);
		{mst, fde, eie, rie, tie} = 5'h02;
		pulse_en(1'b1);
		chkb("miso_off", d_miso_oe, 1'b0);
		cpu(1'b1, 1'b0, 1'b0, 1'b0, 8'ha5);
		repeat (10) tick();
		i_spiirc_far_end.xfer(8'h3c, seen);
		chk("slave_tx", seen, 8'ha5);
		wait_hi(0);
		chk("slave_rx", dreg, 8'h3c);
		chkb("slave_sck", d_sck_oe, 1'b0);
		cpu(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		wt = 1'b1;
		i_spiirc_far_end.xfer(8'h66, seen);
		chk("resend", seen, 8'ha5);
		wait_hi(0);
		chkb("wake", wake, 1'b1);
		cpu(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
		chkb("wait_read", rf, 1'b1);
		wt = 1'b0;
		fde = 1'b1;
		flt = 1'b1;
		repeat (6) tick();
		flt = 1'b0;
		repeat (6) tick();
		chkb("slave_fault", mf, 1'b1);
		chkb("slave_keeps_en", en, 1'b1);
		{mst, rate, fde} = 4'he;
		cpu(1'b1, 1'b0, 1'b0, 1'b0, 8'hff);
		repeat (200) tick();
		stp = 1'b1;
		tick();
		s = d_sck;
		repeat (150)
		begin
			tick();
			chkb("stop_hold", d_sck, s);
		end
		stp = 1'b0;
		repeat (20) tick();
		pulse_en(1'b0);
		chkb("off", en, 1'b0);
		chkb("off_te", te, 1'b1);
		chkb("off_port", port_ctl, 1'b1);
		chkb("off_mosi", d_mosi_oe, 1'b0);
		chkb("off_sck", d_sck_oe, 1'b0);
		chkb("off_rxf", rf, 1'b1);
		chkb("off_ovf", ov, 1'b1);
		chkb("off_irq", rirq, 1'b0);
		rst_i = 1'b1;
		tick();
		chk_reset();
		rst_i = 1'b0;
		stop_test();
	end
endmodule
